// *** include/oseq_pkg.sv ***
package oseq_pkg;

  // ----------------------------------------------------------------
  // Command codes of the sequencing registers
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OK_ON = 8'h5e;
  localparam logic [7:0] CMD_OK_OFF = 8'h5f;
  localparam logic [7:0] CMD_TON_WAIT = 8'h60;
  localparam logic [7:0] CMD_TON_RAMP = 8'h61;
  localparam logic [7:0] CMD_TON_LIMIT = 8'h62;
  localparam logic [7:0] CMD_TON_ACTION = 8'h63;
  localparam logic [7:0] CMD_TOFF_WAIT = 8'h64;
  localparam logic [7:0] CMD_TOFF_RAMP = 8'h65;
  localparam logic [7:0] CMD_TOFF_LIMIT = 8'h66;
  localparam int NUM_REGS = 9;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] ACTION_MASK = 16'h00ff;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int RSP_LSB = 6;
  localparam int RTY_LSB = 3;
  localparam int DLY_LSB = 0;
  localparam int LIN_EXP_LSB = 11;
  localparam logic [1:0] RSP_IGNORE = 2'h0;
  localparam logic [1:0] RSP_OPERATE = 2'h1;
  localparam logic [1:0] RSP_DISABLE = 2'h2;
  localparam logic [1:0] RSP_LATCH = 2'h3;
  localparam logic [2:0] RTY_NONE = 3'h0;
  localparam logic [2:0] RTY_FOREVER = 3'h7;
  localparam int OFF_FRACTION_SHIFT = 3;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_IN_NS = 1000000;
  localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
  localparam int PRE_W = 18;
  localparam int MS_W = 24;

  typedef enum logic [8:0] {
    ST_OFF = 9'h001,
    ST_ON_WAIT = 9'h002,
    ST_RISE = 9'h004,
    ST_ON = 9'h008,
    ST_GRACE = 9'h010,
    ST_RETRY_WAIT = 9'h020,
    ST_LATCH = 9'h040,
    ST_OFF_WAIT = 9'h080,
    ST_FALL = 9'h100
  } oseq_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } oseq_cmd_s;

  typedef struct packed {
    logic [15:0] vout;
    logic [15:0] uv_limit;
    logic [15:0] vout_cmd;
    logic [15:0] unit_ms;
  } oseq_mon_s;

  typedef struct packed {
    oseq_state_e st;
    logic [1:0] sync;
    logic [NUM_REGS-1:0][15:0] regs;
    logic [PRE_W-1:0] pre;
    logic [MS_W-1:0] tmr;
    logic [MS_W-1:0] tmax;
    logic tmax_arm;
    logic [MS_W-1:0] toff_tmr;
    logic toff_run;
    logic [15:0] vcmd_off;
    logic [2:0] tries;
    logic tmax_fault;
    logic toff_warn;
    logic ok;
    logic out_en;
    logic rise;
    logic fall;
    logic rd_valid;
    logic [15:0] rd_data;
  } oseq_state_s;

endpackage

// *** src/oseq_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Raise supply-ok once output reaches the assert threshold, unsigned exp -11.
// - Drop supply-ok when output falls to the separate release threshold.
// - After enable, wait the turn-on wait time in ms before rising.
// - After the wait, ramp up over the turn-on ramp time in ms.
// - Flag startup timeout if output stays below UV limit past the limit.
// - A startup limit of zero disables the timeout.
// - Response 00 ignores the fault and keeps running.
// - Response 01 runs for the delay interval, then applies retry if still failing.
// - Response 10 disables at once, then applies the retry setting.
// - Response 11 latches off until the fault is cleared or the output is commanded off.
// - Retry 000 makes no restart and latches off.
// - Retry 001..110 gives that many restarts, then latches off.
// - Retry 111 restarts without limit until commanded off.
// - Restarts are spaced by the decoded delay times the fault time unit.
// - Delay field 0..7 decodes to 1..128 units, powers of two.
// - The delay unit is the output-voltage fault time unit from outside.
// - Not every response encoding need be honoured by software assumption.
// - After disable, wait the turn-off wait time in ms before falling.
// - After that wait, ramp down over the turn-off ramp time in ms.
// - Warn if output stays above 1/8 of turn-off setpoint past the limit.
module oseq_sequencer #(
  parameter int CYC_PER_MS = oseq_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Command port
  input var oseq_pkg::oseq_cmd_s cmd,
  input wire logic clear_faults,
  output logic rd_valid,
  output logic [15:0] rd_data,
  // Enable sources
  input wire logic ctrl_pin,
  input wire logic op_on,
  // Monitored quantities
  input var oseq_pkg::oseq_mon_s mon,
  // Sequencer outputs
  output logic out_enable,
  output logic ramp_up,
  output logic ramp_down,
  output logic supply_ok_indication,
  output logic startup_timeout_fault,
  output logic shutdown_timeout_warn
);

  oseq_pkg::oseq_state_s s;
  oseq_pkg::oseq_state_s n;

  logic en;
  logic tick;
  logic vlow;
  logic cmd_hit;
  logic [3:0] cmd_idx;
  logic [1:0] rsp;
  logic [2:0] rty;
  logic [2:0] dly;
  logic [oseq_pkg::MS_W-1:0] wait_ms;
  logic [oseq_pkg::MS_W-1:0] ton_ms;
  logic [oseq_pkg::MS_W-1:0] rise_ms;
  logic [oseq_pkg::MS_W-1:0] tlim_ms;
  logic [oseq_pkg::MS_W-1:0] toff_ms;
  logic [oseq_pkg::MS_W-1:0] fall_ms;
  logic [oseq_pkg::MS_W-1:0] wlim_ms;

  // ----------------------------------------------------------------
  // Linear-format time to whole ms
  // ----------------------------------------------------------------
  // Fractions of a ms are dropped; negative mantissa means zero
  function automatic logic [oseq_pkg::MS_W-1:0] lin_ms(input logic [15:0] v);
    logic signed [4:0] e;
    logic [39:0] m;
    logic [39:0] r;
    e = v[15:oseq_pkg::LIN_EXP_LSB];
    m = {29'h0, v[10:0]};
    if (v[10]) begin
      r = 40'h0;
    end else if (e >= 0) begin
      r = m << e;
    end else begin
      r = m >> (-e);
    end
    if (r[39:oseq_pkg::MS_W] != '0) begin
      lin_ms = '1;
    end else begin
      lin_ms = r[oseq_pkg::MS_W-1:0];
    end
  endfunction

  assign ton_ms = lin_ms(s.regs[4'd2]);
  assign rise_ms = lin_ms(s.regs[4'd3]);
  assign tlim_ms = lin_ms(s.regs[4'd4]);
  assign toff_ms = lin_ms(s.regs[4'd6]);
  assign fall_ms = lin_ms(s.regs[4'd7]);
  assign wlim_ms = lin_ms(s.regs[4'd8]);

  assign rsp = s.regs[4'd5][oseq_pkg::RSP_LSB +: 2];
  assign rty = s.regs[4'd5][oseq_pkg::RTY_LSB +: 3];
  assign dly = s.regs[4'd5][oseq_pkg::DLY_LSB +: 3];
  // Unit comes from the voltage fault time unit held elsewhere
  assign wait_ms = {8'h00, mon.unit_ms} << dly;

  assign en = s.sync[1] & op_on;
  assign tick = (s.pre == oseq_pkg::PRE_W'(CYC_PER_MS - 1));
  assign vlow = mon.vout < mon.uv_limit;
  assign cmd_hit = (cmd.code >= oseq_pkg::CMD_OK_ON) && (cmd.code <= oseq_pkg::CMD_TOFF_LIMIT);
  assign cmd_idx = 4'(cmd.code - oseq_pkg::CMD_OK_ON);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.sync = {s.sync[0], ctrl_pin};
    n.pre = tick ? '0 : s.pre + 1'b1;
    n.tmr = (tick && s.tmr != '1) ? s.tmr + 1'b1 : s.tmr;
    n.rd_valid = cmd.rd;
    n.rd_data = 16'h0000;
    if (cmd.rd && cmd_hit) begin
      n.rd_data = s.regs[cmd_idx];
    end
    if (cmd.wr && cmd_hit) begin
      if (cmd.code == oseq_pkg::CMD_TON_ACTION) begin
        n.regs[cmd_idx] = cmd.wdata & oseq_pkg::ACTION_MASK;
      end else begin
        n.regs[cmd_idx] = cmd.wdata;
      end
    end
    if (clear_faults) begin
      n.tmax_fault = 1'b0;
      n.toff_warn = 1'b0;
    end
    if (s.tmax_arm && tick) begin
      n.tmax = s.tmax + 1'b1;
    end
    case (s.st)
      oseq_pkg::ST_OFF: begin
        if (en) begin
          n.st = oseq_pkg::ST_ON_WAIT;
          n.tries = 3'h0;
        end
      end
      oseq_pkg::ST_ON_WAIT: begin
        if (!en) begin
          n.st = oseq_pkg::ST_OFF;
        end else if (s.tmr >= ton_ms) begin
          n.st = oseq_pkg::ST_RISE;
          n.tmax = '0;
          n.tmax_arm = 1'b1;
        end
      end
      oseq_pkg::ST_RISE, oseq_pkg::ST_ON: begin
        if (!en) begin
          n.st = oseq_pkg::ST_OFF_WAIT;
        end else begin
          if (s.st == oseq_pkg::ST_RISE && s.tmr >= rise_ms) begin
            n.st = oseq_pkg::ST_ON;
          end
          if (!vlow) begin
            n.tmax_arm = 1'b0;
          end else if (s.tmax_arm && tlim_ms != '0 && s.tmax >= tlim_ms) begin
            n.tmax_arm = 1'b0;
            n.tmax_fault = 1'b1;
            // Unsupported codes are not expected; all four are honoured
            case (rsp)
              oseq_pkg::RSP_IGNORE: n.tmax_fault = 1'b1;
              oseq_pkg::RSP_OPERATE: n.st = oseq_pkg::ST_GRACE;
              oseq_pkg::RSP_DISABLE: n.st = oseq_pkg::ST_RETRY_WAIT;
              default: n.st = oseq_pkg::ST_LATCH;
            endcase
          end
        end
      end
      oseq_pkg::ST_GRACE: begin
        if (!en) begin
          n.st = oseq_pkg::ST_OFF_WAIT;
        end else if (s.tmr >= wait_ms) begin
          n.st = vlow ? oseq_pkg::ST_RETRY_WAIT : oseq_pkg::ST_ON;
        end
      end
      oseq_pkg::ST_RETRY_WAIT: begin
        if (!en) begin
          n.st = oseq_pkg::ST_OFF;
        end else if (rty == oseq_pkg::RTY_NONE) begin
          n.st = oseq_pkg::ST_LATCH;
        end else if (rty != oseq_pkg::RTY_FOREVER && s.tries >= rty) begin
          n.st = oseq_pkg::ST_LATCH;
        end else if (s.tmr >= wait_ms) begin
          n.st = oseq_pkg::ST_ON_WAIT;
          n.tries = (rty == oseq_pkg::RTY_FOREVER) ? s.tries : s.tries + 3'h1;
        end
      end
      oseq_pkg::ST_LATCH: begin
        // Off command or a clear releases the latch
        if (!en || clear_faults) begin
          n.st = oseq_pkg::ST_OFF;
        end
      end
      oseq_pkg::ST_OFF_WAIT: begin
        if (s.tmr >= toff_ms) begin
          n.st = oseq_pkg::ST_FALL;
        end
      end
      oseq_pkg::ST_FALL: begin
        if (s.tmr >= fall_ms) begin
          n.st = oseq_pkg::ST_OFF;
        end
      end
      default: n.st = oseq_pkg::ST_OFF;
    endcase
    if (n.st != s.st) begin
      n.pre = '0;
      n.tmr = '0;
    end
    // Shutdown watch starts at the disable request and outlives the ramp
    if (n.st == oseq_pkg::ST_OFF_WAIT && s.st != oseq_pkg::ST_OFF_WAIT) begin
      n.toff_run = 1'b1;
      n.toff_tmr = '0;
      n.vcmd_off = mon.vout_cmd;
    end else if (s.toff_run) begin
      if (mon.vout < (s.vcmd_off >> oseq_pkg::OFF_FRACTION_SHIFT)) begin
        n.toff_run = 1'b0;
      end else if (wlim_ms != '0 && s.toff_tmr >= wlim_ms) begin
        n.toff_run = 1'b0;
        n.toff_warn = 1'b1;
      end else if (tick) begin
        n.toff_tmr = s.toff_tmr + 1'b1;
      end
    end
    n.out_en = (n.st == oseq_pkg::ST_RISE) || (n.st == oseq_pkg::ST_ON) ||
               (n.st == oseq_pkg::ST_GRACE) || (n.st == oseq_pkg::ST_OFF_WAIT) ||
               (n.st == oseq_pkg::ST_FALL);
    n.rise = n.st == oseq_pkg::ST_RISE;
    n.fall = n.st == oseq_pkg::ST_FALL;
    if (!n.out_en) begin
      n.ok = 1'b0;
    end else if (mon.vout >= s.regs[4'd0]) begin
      n.ok = 1'b1;
    end else if (mon.vout <= s.regs[4'd1]) begin
      n.ok = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: oseq_pkg::ST_OFF, regs: {oseq_pkg::NUM_REGS{oseq_pkg::REG_RESET}}, default: '0};
    end else begin
      s <= n;
    end
  end

  assign out_enable = s.out_en;
  assign ramp_up = s.rise;
  assign ramp_down = s.fall;
  assign supply_ok_indication = s.ok;
  assign startup_timeout_fault = s.tmax_fault;
  assign shutdown_timeout_warn = s.toff_warn;
  assign rd_valid = s.rd_valid;
  assign rd_data = s.rd_data;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ok_assert_a: assert property ($rose(s.ok) |-> $past(mon.vout) >= $past(s.regs[4'd0]))
    else $error("supply ok rose below threshold");
  ok_release_a: assert property ($fell(s.ok) && s.out_en |-> $past(mon.vout) <= $past(s.regs[4'd1]))
    else $error("supply ok fell above release");
  on_wait_a: assert property ($rose(s.st == oseq_pkg::ST_RISE) |-> $past(s.tmr) >= $past(ton_ms))
    else $error("rise began before wait");
  rise_time_a: assert property (s.st == oseq_pkg::ST_ON && $past(s.st) == oseq_pkg::ST_RISE
      |-> $past(s.tmr) >= $past(rise_ms))
    else $error("ramp ended early");
  tmax_cause_a: assert property ($rose(s.tmax_fault) |-> $past(vlow) && $past(s.tmax) >= $past(tlim_ms))
    else $error("timeout without cause");
  tmax_zero_a: assert property ($rose(s.tmax_fault) |-> $past(tlim_ms) != '0)
    else $error("timeout with zero limit");
  ignore_run_a: assert property ($rose(s.tmax_fault) && $past(rsp) == oseq_pkg::RSP_IGNORE
      |-> s.out_en)
    else $error("ignore response stopped output");
  disable_now_a: assert property ($rose(s.tmax_fault) && $past(rsp) == oseq_pkg::RSP_DISABLE
      |-> !s.out_en)
    else $error("disable response kept output");
  latch_hold_a: assert property (s.st == oseq_pkg::ST_LATCH && en && !clear_faults
      |=> s.st == oseq_pkg::ST_LATCH && !s.out_en)
    else $error("latch released early");
  no_retry_a: assert property (s.st == oseq_pkg::ST_RETRY_WAIT && rty == oseq_pkg::RTY_NONE && en
      |=> s.st == oseq_pkg::ST_LATCH)
    else $error("restart with retry zero");
  off_wait_a: assert property ($rose(s.st == oseq_pkg::ST_FALL) |-> $past(s.tmr) >= $past(toff_ms))
    else $error("fall began before wait");
  warn_cause_a: assert property ($rose(s.toff_warn)
      |-> $past(mon.vout) >= ($past(s.vcmd_off) >> oseq_pkg::OFF_FRACTION_SHIFT))
    else $error("warning with output low");

  // Waits may not be cut short while enabled; each hold checks one timer against its limit
  ton_hold_a: assert property (
      s.st == oseq_pkg::ST_ON_WAIT && en && s.tmr < ton_ms |=> s.st == oseq_pkg::ST_ON_WAIT)
    else $error("turn-on wait cut short");
  grace_hold_a: assert property (
      s.st == oseq_pkg::ST_GRACE && en && s.tmr < wait_ms |=> s.st == oseq_pkg::ST_GRACE)
    else $error("grace interval cut short");
  grace_retry_a: assert property (
      s.st == oseq_pkg::ST_GRACE && en && s.tmr >= wait_ms && vlow |=> s.st == oseq_pkg::ST_RETRY_WAIT)
    else $error("grace end ignored fault");
  retry_limit_a: assert property (
      s.st == oseq_pkg::ST_RETRY_WAIT && en && rty != oseq_pkg::RTY_NONE && rty != oseq_pkg::RTY_FOREVER
      && s.tries >= rty |=> s.st == oseq_pkg::ST_LATCH)
    else $error("retries exceeded limit");
  retry_ever_a: assert property (
      s.st == oseq_pkg::ST_RETRY_WAIT && en && rty == oseq_pkg::RTY_FOREVER && s.tmr >= wait_ms
      |=> s.st == oseq_pkg::ST_ON_WAIT)
    else $error("endless retry stopped");
  retry_space_a: assert property (
      $rose(s.st == oseq_pkg::ST_ON_WAIT) && $past(s.st) == oseq_pkg::ST_RETRY_WAIT
      |-> $past(s.tmr) >= $past(wait_ms))
    else $error("restart came too soon");
  toff_hold_a: assert property (
      s.st == oseq_pkg::ST_OFF_WAIT && s.tmr < toff_ms |=> s.st == oseq_pkg::ST_OFF_WAIT)
    else $error("turn-off wait cut short");
  fall_time_a: assert property (
      s.st == oseq_pkg::ST_OFF && $past(s.st) == oseq_pkg::ST_FALL |-> $past(s.tmr) >= $past(fall_ms))
    else $error("fall ended early");
  ok_off_a: assert property (!s.out_en |-> !s.ok)
    else $error("supply ok with output off");
  no_limit_a: assert property (tlim_ms == '0 && !s.tmax_fault |=> !s.tmax_fault)
    else $error("timeout raised with no limit");

  retry_cover_c: cover property (s.st == oseq_pkg::ST_RETRY_WAIT ##1 s.st == oseq_pkg::ST_ON_WAIT);
  latch_cover_c: cover property ($rose(s.st == oseq_pkg::ST_LATCH));
  warn_cover_c: cover property ($rose(s.toff_warn));
  grace_cover_c: cover property (s.st == oseq_pkg::ST_GRACE ##1 s.st == oseq_pkg::ST_ON);
  ignore_cover_c: cover property ($rose(s.tmax_fault) && rsp == oseq_pkg::RSP_IGNORE);

endmodule

`default_nettype wire

// *** verification/oseq_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module oseq_host_model (
  // Clock
  input wire logic sys_clk,
  // Command side
  output oseq_pkg::oseq_cmd_s cmd,
  output logic clear_faults,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data
);
  // ----------------------------------------------------------------
  // Host transfers
  // ----------------------------------------------------------------
  initial begin
    cmd = '0;
    clear_faults = 1'b0;
  end

  // Whole milliseconds with a zero exponent
  function automatic logic [15:0] lin_ms(input logic [10:0] ms);
    return {5'h00, ms};
  endfunction

  // Released code and data lines show the inverse of their last value; wr and rd go low
  task automatic put(input logic w, input logic [7:0] code, input logic [15:0] data);
    @(posedge sys_clk);
    #1;
    cmd.code = code;
    cmd.wdata = data;
    cmd.wr = w;
    cmd.rd = !w;
    @(posedge sys_clk);
    #1;
    cmd.wr = 1'b0;
    cmd.rd = 1'b0;
    cmd.code = ~code;
    cmd.wdata = ~data;
  endtask

  task automatic write_reg(input logic [7:0] code, input logic [15:0] data);
    put(1'b1, code, data);
  endtask

  task automatic read_reg(input logic [7:0] code, output logic [15:0] data);
    data = 16'hxxxx;
    put(1'b0, code, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      if (rd_valid === 1'b1) begin
        data = rd_data;
        break;
      end
      @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic pulse_clear;
    @(posedge sys_clk);
    #1;
    clear_faults = 1'b1;
    @(posedge sys_clk);
    #1;
    clear_faults = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verification/test_output_sequencing_fault_retry.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_output_sequencing_fault_retry;
  // ----------------------------------------------------------------
  // Bench state
  // ----------------------------------------------------------------
  typedef struct {logic [7:0] code; logic [15:0] wd; logic [15:0] exp;} oseq_row_s;
  typedef struct {logic [7:0] act; int rises; logic on;} oseq_flt_s;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ctrl_pin = 1'b0;
  logic op_on = 1'b0;
  oseq_pkg::oseq_cmd_s cmd;
  oseq_pkg::oseq_mon_s mon = '0;
  logic clear_faults, rd_valid, out_enable, ramp_up, ramp_down, ok_ind, flt, warn, p;
  logic [15:0] rd_data, rv;
  int error_cnt = 0;
  int cmp_count = 0;
  int n, r, g, f;
  oseq_row_s rows[11] = '{'{8'h5e, 16'h1000, 16'h1000}, '{8'h5f, 16'h0c00, 16'h0c00},
    '{8'h60, 16'h0002, 16'h0002}, '{8'h61, 16'h0003, 16'h0003}, '{8'h62, 16'h0000, 16'h0000},
    '{8'h63, 16'hff00, 16'h0000}, '{8'h64, 16'h0002, 16'h0002}, '{8'h65, 16'h0002, 16'h0002},
    '{8'h66, 16'h0003, 16'h0003}, '{8'h67, 16'h1234, 16'h0000}, '{8'h5d, 16'hffff, 16'h0000}};
  oseq_flt_s flts[7] = '{'{8'h00, 1, 1'b1}, '{8'h51, 3, 1'b0}, '{8'h90, 3, 1'b0},
    '{8'hc0, 1, 1'b0}, '{8'h80, 1, 1'b0}, '{8'h8b, 2, 1'b0}, '{8'hb8, 0, 1'b0}};

  always #2 sys_clk = ~sys_clk;

  oseq_host_model hm (.sys_clk(sys_clk), .cmd(cmd), .clear_faults(clear_faults), .rd_valid(rd_valid),
    .rd_data(rd_data));
  oseq_sequencer #(.CYC_PER_MS(10)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd),
    .clear_faults(clear_faults), .rd_valid(rd_valid), .rd_data(rd_data), .ctrl_pin(ctrl_pin),
    .op_on(op_on), .mon(mon), .out_enable(out_enable), .ramp_up(ramp_up), .ramp_down(ramp_down),
    .supply_ok_indication(ok_ind), .startup_timeout_fault(flt), .shutdown_timeout_warn(warn));

  task automatic final_report;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    chk_val({15'h0000, got}, {15'h0000, exp}, m);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return ramp_up;
      1: return out_enable;
      2: return ok_ind;
      4: return ramp_down;
      default: return warn;
    endcase
  endfunction

  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // Bounded wait, counted as one comparison
  task automatic wait_for(input int s, input logic lv, input int mx);
    n = 0;
    cmp_count++;
    while (sig(s) !== lv && n < mx) begin
      step(1);
      n++;
    end
    if (n >= mx) begin
      error_cnt++;
      $display("CHECK FAILED %0t wait on output %0d timed out", $time, s);
      final_report();
    end
  endtask

  task automatic shut;
    op_on = 1'b0;
    step(80);
    hm.pulse_clear();
    step(2);
  endtask

  initial begin
    #200000;
    error_cnt++;
    $display("CHECK FAILED %0t run timed out", $time);
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    step(16);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      hm.read_reg(rows[i].code, rv);
      chk_val(rv, 16'h0000, "reset value");
      hm.write_reg(rows[i].code, rows[i].wd);
      hm.read_reg(rows[i].code, rv);
      chk_val(rv, rows[i].exp, "read back");
    end
    mon.uv_limit = 16'h0800;
    mon.unit_ms = 16'h0001;
    mon.vout_cmd = 16'h1800;
    ctrl_pin = 1'b1;
    op_on = 1'b1;
    wait_for(0, 1'b1, 40);
    chk_bit(n >= 20 && n <= 26, 1'b1, "turn-on wait");
    chk_bit(out_enable, 1'b1, "enable with ramp");
    wait_for(0, 1'b0, 40);
    chk_bit(n >= 29 && n <= 32, 1'b1, "rise length");
    step(100);
    chk_bit(flt, 1'b0, "zero limit");
    chk_bit(ok_ind, 1'b0, "below assert level");
    mon.vout = 16'h1000;
    wait_for(2, 1'b1, 3);
    mon.vout = 16'h0c01;
    step(5);
    chk_bit(ok_ind, 1'b1, "hysteresis");
    mon.vout = 16'h0c00;
    wait_for(2, 1'b0, 3);
    mon.vout = 16'h1800;
    ctrl_pin = 1'b0;
    wait_for(4, 1'b1, 30);
    chk_bit(n >= 20, 1'b1, "turn-off wait");
    wait_for(4, 1'b0, 26);
    chk_bit(n >= 19, 1'b1, "fall length");
    wait_for(1, 1'b0, 3);
    wait_for(5, 1'b1, 60);
    hm.pulse_clear();
    step(2);
    chk_bit(warn, 1'b0, "warning cleared");
    ctrl_pin = 1'b1;
    op_on = 1'b0;
    mon.vout = 16'h0000;
    mon.unit_ms = 16'h0002;
    hm.write_reg(oseq_pkg::CMD_TON_LIMIT, hm.lin_ms(11'h002));
    // Fault responses: attempts counted as rising edges of the output
    foreach (flts[i]) begin
      hm.write_reg(oseq_pkg::CMD_TON_ACTION, {8'h00, flts[i].act});
      op_on = 1'b1;
      r = 0;
      g = 100000;
      f = -1;
      p = 1'b0;
      for (int k = 0; k < 600; k++) begin
        step(1);
        if (out_enable && !p) begin
          r++;
          if (f >= 0 && k - f < g)
            g = k - f;
        end
        if (!out_enable && p)
          f = k;
        p = out_enable;
      end
      chk_bit(flt, 1'b1, "startup fault");
      if (flts[i].rises > 0) begin
        chk_val(r[15:0], flts[i].rises[15:0], "attempts");
        chk_bit(out_enable, flts[i].on, "final output");
      end else begin
        chk_bit(r >= 4, 1'b1, "endless retry");
      end
      if (r > 1)
        chk_bit(g >= (1 << flts[i].act[2:0]) * 20 + 20, 1'b1, "retry spacing");
      shut();
    end
    op_on = 1'b1;
    step(30);
    rst_n = 1'b0;
    step(2);
    chk_bit(out_enable, 1'b0, "output off in reset");
    rst_n = 1'b1;
    hm.read_reg(oseq_pkg::CMD_TON_WAIT, rv);
    chk_val(rv, 16'h0000, "register after reset");
    final_report();
  end
endmodule
`default_nettype wire
